// ---- hsad_async_desc_sva.sv ----
module hsad_sva
  import hsad_pkg::*;
(
  // Clock and reset
  input wire logic                  REF_CLK_I,
  input wire logic                  RST_I,
  // APB
  input wire logic                  PSEL_I,
  input wire logic                  PENABLE_I,
  input wire logic                  PWRITE_I,
  input wire logic [DATA_W-1:0]     PRDATA_O,
  input wire logic                  PREADY_O,
  input wire logic                  PSLVERR_O,
  // Issue
  input wire logic                  XFER_VALID_O,
  input wire logic [1:0]            MULT_O,
  input wire logic [15:0]           PAYLOAD_START_O,
  input wire logic [CPU_ADDR_W-1:0] PAYLOAD_CPU_ADDR_O
);
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (RST_I);
  sequence s_setup;
    PSEL_I && !PENABLE_I;
  endsequence
  sequence s_access;
    PSEL_I && PENABLE_I;
  endsequence
  a_ready_pulse: assert property (PREADY_O |=> !PREADY_O)
    else $error("pready held too long");
  a_ready_wait: assert property (s_setup ##1 s_access |-> ##[1:5] PREADY_O)
    else $error("no pready in time");
  a_ready_in_access: assert property (PREADY_O |-> s_access)
    else $error("pready outside access");
  a_err_with_ready: assert property (PSLVERR_O |-> PREADY_O)
    else $error("pslverr without pready");
  a_err_zero_data: assert property (PSLVERR_O && !PWRITE_I |-> PRDATA_O == '0)
    else $error("refused read data not zero");
  a_rdata_hold: assert property (!PREADY_O |-> $stable(PRDATA_O))
    else $error("prdata moved between answers");
  a_cpu_addr: assert property (XFER_VALID_O |->
    PAYLOAD_CPU_ADDR_O == ({4'h0, PAYLOAD_START_O} << 3) + PAYLOAD_BASE)
    else $error("payload cpu address wrong");
  a_mult_defined: assert property (XFER_VALID_O |-> MULT_O != MULT_UNDEF)
    else $error("issued with undefined multiplier");
endmodule : hsad_sva

bind hsad_async_desc hsad_sva u_sva (
  .REF_CLK_I          (REF_CLK_I),
  .RST_I              (RST_I),
  .PSEL_I             (PSEL_I),
  .PENABLE_I          (PENABLE_I),
  .PWRITE_I           (PWRITE_I),
  .PRDATA_O           (PRDATA_O),
  .PREADY_O           (PREADY_O),
  .PSLVERR_O          (PSLVERR_O),
  .XFER_VALID_O       (XFER_VALID_O),
  .MULT_O             (MULT_O),
  .PAYLOAD_START_O    (PAYLOAD_START_O),
  .PAYLOAD_CPU_ADDR_O (PAYLOAD_CPU_ADDR_O)
);

// ---- hsad_async_desc_tb.sv ----
module hsad_async_desc_tb;
  import hsad_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [31:0] d; logic e; logic r;} hsad_exp_t;
  hsad_exp_t   q[$];
  hsad_exp_t   x;
  logic        clk, rst, psel, pen, pwr, pready, pslverr, xv, sp, spo, bk;
  logic        rv, rr, go, busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0]  tok, mu, rk, gk, tk, ty, m, rt;
  logic [6:0]  fa, fao;
  logic [3:0]  ep, epo, rl;
  logic [15:0] ps, pso;
  logic [19:0] pca;
  logic [14:0] rb, gb, tot;
  logic [4:0]  gn;
  int          err_total, n_compared, cyc, sd;

  hsad_async_desc dut (.REF_CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .XFER_VALID_O(xv), .TOKEN_O(tok),
    .FUNC_ADDR_O(fao), .ENDPOINT_O(epo), .SPLIT_O(spo), .BULK_O(bk), .MULT_O(mu),
    .PAYLOAD_START_O(pso), .PAYLOAD_CPU_ADDR_O(pca), .RES_VALID_I(rv),
    .RES_READY_O(rr), .RES_KIND_I(rk), .RES_BYTES_I(rb));
  hsad_ep_model u_ep (.clk_i(clk), .rst_i(rst), .go_i(go), .n_i(gn), .kind_i(gk),
    .bytes_i(gb), .vld_o(rv), .rdy_i(rr), .kind_o(rk), .bytes_o(rb), .busy_o(busy));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("Compared %0d, errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic apb(logic w, logic [11:0] a, logic [31:0] d, logic [31:0] e, logic er);
    q.push_back('{e, er, !w});
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    psel <= 1'b0;
    pen <= 1'b0;
    // Idle cycle so a following call never reassigns psel in this time step
    @(posedge clk);
  endtask : apb

  task automatic wr(logic [11:0] a, logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 1'b0);
  endtask : wr

  task automatic rd(logic [11:0] a, logic [31:0] e);
    apb(1'b0, a, 32'h0, e, 1'b0);
  endtask : rd

  function automatic logic [31:0] w3(logic [1:0] r, logic [3:0] n, logic [14:0] b);
    return {7'h00, r, n, 4'h0, b};
  endfunction : w3

  task automatic cfg(logic [1:0] k, logic [1:0] mm, logic [14:0] t, logic [3:0] r, logic [1:0] e);
    tk = k;
    m = mm;
    tot = t;
    rl = r;
    rt = e;
    wr(OFS_WORD1, {17'h00000, sp, ty, tk, fa, ep[3:1]});
    wr(OFS_WORD2, {3'h0, rl, 1'h0, ps, 8'h00});
    wr(OFS_WORD3, w3(rt, rl, 15'h0000));
    wr(OFS_WORD0, {ep[0], m, 11'h000, tot, 3'h1});
    repeat (3) @(posedge clk);
  endtask : cfg

  task automatic send(logic [1:0] k, logic [14:0] b, logic [4:0] n, logic wt);
    gk <= k;
    gb <= b;
    gn <= n;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    while (wt && busy)
      @(posedge clk);
    repeat (8) @(posedge clk);
  endtask : send

  always @(posedge clk)
    if (psel && pen && pready === 1'b1)
    begin
      x = q.pop_front();
      chk("pslverr", x.e, pslverr);
      if (x.r)
        chk("prdata", x.d, prdata);
    end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      err_total++;
      report_and_stop();
    end
  end

  initial
  begin
    rst = 1'b1;
    {psel, pen, pwr, paddr, pwdata, go, gn, gk, gb, sp, ty, fa, ep, ps} = 100'h0;
    sd = 17498;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 5; i++)
      rd(12'(i * 4), 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      {sp, fa, ep, ps} = 28'($random(sd));
      ty = {i[0], 1'b0};
      cfg(2'(i % 3), 2'(1 + i % 3), 15'd0, 4'h0, 2'h0);
      chk("xfer_valid", 1, xv);
      chk("token", tk, tok);
      chk("func", fa, fao);
      chk("endpoint", ep, epo);
      chk("split", sp, spo);
      chk("bulk", ty[1], bk);
      chk("mult", m, mu);
      chk("payload", ps, pso);
      chk("cpu_addr", ({4'h0, ps} << 3) + 20'h00400, pca);
    end
    wr(OFS_WORD1, {17'h00000, sp, ty, TOKEN_PING, fa, ep[3:1]});
    repeat (3) @(posedge clk);
    chk("sw_ping", tk, tok);
    wr(OFS_WORD0, {ep[0], MULT_UNDEF, 11'h000, 15'd0, 3'h1});
    repeat (3) @(posedge clk);
    chk("mult_undef", 0, xv);
    sp = 1'b0;
    cfg(TOKEN_IN, MULT_ONE, 15'd100, 4'h0, 2'h3);
    send(RES_ERR, 15'd0, 5'd3, 1'b1);
    rd(OFS_WORD3, w3(2'h0, 4'h0, 15'd0));
    send(RES_ERR, 15'd0, 5'd1, 1'b1);
    rd(OFS_WORD0, {ep[0], m, 11'h000, tot, 3'h0});
    rd(OFS_STATUS, {28'h0, CAUSE_ERR, 2'h0});
    cfg(TOKEN_IN, MULT_ONE, 15'd100, 4'h2, 2'h0);
    send(RES_NAK, 15'd0, 5'd1, 1'b1);
    rd(OFS_WORD3, w3(2'h0, 4'h1, 15'd0));
    send(RES_ACK, 15'd0, 5'd1, 1'b1);
    rd(OFS_WORD3, w3(2'h0, 4'h2, 15'd0));
    send(RES_NAK, 15'd0, 5'd2, 1'b1);
    rd(OFS_STATUS, {28'h0, CAUSE_NAK, 2'h0});
    rd(OFS_WORD3, w3(2'h0, 4'h0, 15'd0));
    cfg(TOKEN_OUT, MULT_ONE, 15'd100, 4'h0, 2'h0);
    send(RES_NAK, 15'd0, 5'd5, 1'b1);
    chk("nak_ignored", 1, xv);
    chk("ping", TOKEN_PING, tok);
    send(RES_ACK, 15'd0, 5'd1, 1'b1);
    chk("ping_ack", TOKEN_OUT, tok);
    cfg(TOKEN_IN, 2'h2, 15'd100, 4'h0, 2'h0);
    send(RES_ACK, 15'd40, 5'd1, 1'b1);
    rd(OFS_WORD3, w3(2'h0, 4'h0, 15'd40));
    send(RES_ACK, 15'd60, 5'd1, 1'b1);
    rd(OFS_STATUS, {28'h0, CAUSE_DONE, 2'h0});
    rd(OFS_WORD3, w3(2'h0, 4'h0, 15'd100));
    wr(OFS_WORD0, 32'h0);
    send(RES_ACK, 15'd0, 5'd17, 1'b0);
    repeat (150) @(posedge clk);
    chk("fifo_full", 0, rr);
    cfg(TOKEN_IN, 2'h2, 15'h7FFF, 4'h0, 2'h0);
    // Let the queued records drain; a new batch command would race the pending one
    repeat (80) @(posedge clk);
    chk("fifo_drained", 1, rr);
    rd(OFS_STATUS, 32'h0);
    apb(1'b0, 12'h014, 32'h0, 32'h0, 1'b1);
    apb(1'b1, 12'h020, 32'hFFFF_FFFF, 32'h0, 1'b1);
    repeat (4) @(posedge clk);
    report_and_stop();
  end
endmodule : hsad_async_desc_tb

// ---- hsad_ep_model.sv ----
module hsad_ep_model (
  // Clock and reset
  input wire logic         clk_i,
  input wire logic         rst_i,
  // Batch command
  input wire logic         go_i,
  input wire logic [4:0]   n_i,
  input wire logic [1:0]   kind_i,
  input wire logic [14:0]  bytes_i,
  // Result records
  output logic             vld_o,
  input wire logic         rdy_i,
  output logic [1:0]       kind_o,
  output logic [14:0]      bytes_o,
  output logic             busy_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] n_q;
  int         sd = 17498;
  // Random gaps model a slow endpoint; idle lines show inverted data
  always @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      n_q <= 5'h00;
      vld_o <= 1'b0;
      kind_o <= 2'h0;
      bytes_o <= 15'h0000;
    end
    else if (go_i)
      n_q <= n_i;
    else if (vld_o && rdy_i)
    begin
      vld_o <= 1'b0;
      kind_o <= ~kind_o;
      bytes_o <= ~bytes_o;
      n_q <= n_q - 5'h01;
    end
    else if (!vld_o && n_q != 5'h00 && $random(sd) % 2 == 0)
    begin
      vld_o <= 1'b1;
      kind_o <= kind_i;
      bytes_o <= bytes_i;
    end
  assign busy_o = n_q != 5'h00;
endmodule : hsad_ep_model

// ---- hsad_fields.sv ----
module hsad_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Filling side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Draining side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    wr_d;
  logic [AW-1:0]    rd_q;
  logic [AW-1:0]    rd_d;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  logic             ready_q;
  logic             ready_d;
  logic             push;
  logic             pop;

  always_comb
  begin
    push = in_valid_i & ready_q;
    pop = (cnt_q != '0) & out_ready_i;
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
    cnt_d = cnt_q;
    if (push & ~pop)
    begin
      cnt_d = cnt_q + 1'b1;
    end
    else if (pop & ~push)
    begin
      cnt_d = cnt_q - 1'b1;
    end
    ready_d = cnt_d != FULL_CNT;
  end

  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      ready_q <= 1'b1;
    end
    else
    begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      ready_q <= ready_d;
    end
  end

  assign in_ready_o = ready_q;
  assign out_valid_o = cnt_q != '0;
  assign out_data_o = mem_q[rd_q];
endmodule : hsad_fifo

module hsad_async_desc (
  // Clock and reset
  input  wire logic                           REF_CLK_I,
  input  wire logic                           RST_I,
  // APB slave
  input  wire logic                           PSEL_I,
  input  wire logic                           PENABLE_I,
  input  wire logic                           PWRITE_I,
  input  wire logic [hsad_pkg::ADDR_W-1:0]    PADDR_I,
  input  wire logic [hsad_pkg::DATA_W-1:0]    PWDATA_I,
  output logic [hsad_pkg::DATA_W-1:0]         PRDATA_O,
  output logic                                PREADY_O,
  output logic                                PSLVERR_O,
  // Transaction issued toward the endpoint
  output logic                                XFER_VALID_O,
  output logic [1:0]                          TOKEN_O,
  output logic [6:0]                          FUNC_ADDR_O,
  output logic [3:0]                          ENDPOINT_O,
  output logic                                SPLIT_O,
  output logic                                BULK_O,
  output logic [1:0]                          MULT_O,
  output logic [15:0]                         PAYLOAD_START_O,
  output logic [hsad_pkg::CPU_ADDR_W-1:0]     PAYLOAD_CPU_ADDR_O,
  // Transaction results
  input  wire logic                           RES_VALID_I,
  output logic                                RES_READY_O,
  input  wire logic [1:0]                     RES_KIND_I,
  input  wire logic [hsad_pkg::BYTES_W-1:0]   RES_BYTES_I
);
  import hsad_pkg::*;

  function automatic logic type_ok(input logic [1:0] code);
    type_ok = (code == TYPE_CONTROL) || (code == TYPE_BULK);
  endfunction : type_ok

  function automatic logic [1:0] word_index(input logic [ADDR_W-1:0] a);
    word_index = a[3:2];
  endfunction : word_index

  function automatic logic is_word(input logic [ADDR_W-1:0] a);
    is_word = (a >= OFS_WORD0) && (a <= OFS_WORD3) && (a[1:0] == 2'h0);
  endfunction : is_word

  logic [DATA_W-1:0]  dw_q [4];
  logic [DATA_W-1:0]  dw_d [4];
  hsad_state_t        st_q;
  hsad_state_t        st_d;
  logic [FIFO_W-1:0]  rec_q;
  logic [FIFO_W-1:0]  rec_d;
  logic [1:0]         retry_q;
  logic [1:0]         retry_d;
  logic [3:0]         nak_q;
  logic [3:0]         nak_d;
  logic [1:0]         token_q;
  logic [1:0]         token_d;
  logic [BYTES_W-1:0] acc_q;
  logic [BYTES_W-1:0] acc_d;
  logic [1:0]         cause_q;
  logic [1:0]         cause_d;
  logic [1:0]         next_cause_q;
  logic [1:0]         next_cause_d;
  logic [DATA_W-1:0]  prdata_q;
  logic [DATA_W-1:0]  prdata_d;
  logic               pready_q;
  logic               pready_d;
  logic               pslverr_q;
  logic               pslverr_d;
  logic               xv_q;
  logic               xv_d;
  logic [1:0]         tok_o_q;
  logic [6:0]         func_q;
  logic [3:0]         ep_q;
  logic               split_q;
  logic               bulk_q;
  logic [1:0]         mult_q;
  logic [15:0]        pay_q;
  logic [CPU_ADDR_W-1:0] cpu_q;
  logic               fifo_valid;
  logic [FIFO_W-1:0]  fifo_data;
  logic               pop;
  logic               commit;
  logic [1:0]         wi;

  // Result records wait here; popping stalls during bus accesses
  hsad_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_res_fifo (
    .clk_i       (REF_CLK_I),
    .rst_i       (RST_I),
    .in_valid_i  (RES_VALID_I),
    .in_ready_o  (RES_READY_O),
    .in_data_i   ({RES_KIND_I, RES_BYTES_I}),
    .out_valid_o (fifo_valid),
    .out_ready_i (pop),
    .out_data_o  (fifo_data)
  );

  // Bus and descriptor update
  always_comb
  begin
    dw_d = dw_q;
    st_d = st_q;
    rec_d = rec_q;
    retry_d = retry_q;
    nak_d = nak_q;
    token_d = token_q;
    acc_d = acc_q;
    cause_d = cause_q;
    next_cause_d = next_cause_q;
    prdata_d = prdata_q;
    pslverr_d = 1'b0;
    wi = word_index(PADDR_I);
    commit = PSEL_I & PENABLE_I & pready_q;
    pop = (st_q == ST_IDLE) & ~PSEL_I & dw_q[0][W0_VALID] & fifo_valid;
    // One wait state; none granted while the engine owns the words
    pready_d = PSEL_I & PENABLE_I & ~pready_q & (st_q == ST_IDLE);
    if (pready_d)
    begin
      pslverr_d = ~is_word(PADDR_I) && (PADDR_I != OFS_STATUS);
      if (is_word(PADDR_I))
      begin
        prdata_d = dw_q[wi];
      end
      else if (PADDR_I == OFS_STATUS)
      begin
        prdata_d = {28'h0000000, cause_q, st_q};
      end
      else
      begin
        prdata_d = WORD_RESET;
      end
    end
    if (commit && PWRITE_I && is_word(PADDR_I))
    begin
      dw_d[wi] = PWDATA_I;
      if (wi == 2'h1 && PWDATA_I[W1_TOKEN_LSB +: 2] == TOKEN_PING)
      begin
        dw_d[1][W1_TOKEN_LSB +: 2] = dw_q[1][W1_TOKEN_LSB +: 2];
      end
      if (wi == 2'h0)
      begin
        acc_d = '0;
        cause_d = CAUSE_NONE;
      end
    end
    unique case (st_q)
      ST_IDLE:
      begin
        if (pop)
        begin
          rec_d = fifo_data;
          retry_d = dw_q[3][W3_RETRY_LSB +: 2];
          nak_d = dw_q[3][W3_NAK_LSB +: 4];
          token_d = dw_q[1][W1_TOKEN_LSB +: 2];
          st_d = ST_EVAL;
        end
      end
      ST_EVAL:
      begin
        next_cause_d = CAUSE_NONE;
        if (rec_q[FIFO_W-1 -: 2] == RES_ERR)
        begin
          if (retry_q == 2'h0)
          begin
            next_cause_d = CAUSE_ERR;
          end
          else
          begin
            retry_d = retry_q - 2'h1;
          end
        end
        else if (rec_q[FIFO_W-1 -: 2] == RES_NAK)
        begin
          if (token_q == TOKEN_OUT && !dw_q[1][W1_SPLIT])
          begin
            token_d = TOKEN_PING;
          end
          if (dw_q[2][W2_RELOAD_LSB +: 4] != 4'h0)
          begin
            nak_d = (nak_q == 4'h0) ? 4'h0 : nak_q - 4'h1;
            if (nak_d == 4'h0)
            begin
              next_cause_d = CAUSE_NAK;
            end
          end
        end
        else
        begin
          nak_d = dw_q[2][W2_RELOAD_LSB +: 4];
          if (token_q == TOKEN_PING)
          begin
            token_d = TOKEN_OUT;
          end
          else
          begin
            acc_d = acc_q + rec_q[BYTES_W-1:0];
            if (acc_d >= dw_q[0][W0_TOTAL_LSB +: BYTES_W])
            begin
              next_cause_d = CAUSE_DONE;
            end
          end
        end
        st_d = ST_WB;
      end
      ST_WB:
      begin
        // Status lands before valid drops
        dw_d[3][W3_RETRY_LSB +: 2] = retry_q;
        dw_d[3][W3_NAK_LSB +: 4] = nak_q;
        dw_d[1][W1_TOKEN_LSB +: 2] = token_q;
        if (dw_q[0][W0_MULT_LSB +: 2] != MULT_ONE || next_cause_q != CAUSE_NONE)
        begin
          dw_d[3][W3_BYTES_LSB +: BYTES_W] = acc_q;
        end
        st_d = (next_cause_q == CAUSE_NONE) ? ST_IDLE : ST_RETIRE;
      end
      ST_RETIRE:
      begin
        dw_d[0][W0_VALID] = 1'b0;
        cause_d = next_cause_q;
        st_d = ST_IDLE;
      end
    endcase
  end

  // Issued transaction fields
  always_comb
  begin
    xv_d = dw_q[0][W0_VALID] && (dw_q[0][W0_MULT_LSB +: 2] != MULT_UNDEF)
           && type_ok(dw_q[1][W1_TYPE_LSB +: 2]) && (st_q == ST_IDLE);
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      for (int i = 0; i < 4; i++)
      begin
        dw_q[i] <= WORD_RESET;
      end
      st_q <= ST_IDLE;
      rec_q <= '0;
      retry_q <= '0;
      nak_q <= '0;
      token_q <= TOKEN_OUT;
      acc_q <= '0;
      cause_q <= CAUSE_NONE;
      next_cause_q <= CAUSE_NONE;
      prdata_q <= WORD_RESET;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      xv_q <= 1'b0;
      tok_o_q <= TOKEN_OUT;
      func_q <= '0;
      ep_q <= '0;
      split_q <= 1'b0;
      bulk_q <= 1'b0;
      mult_q <= MULT_UNDEF;
      pay_q <= '0;
      cpu_q <= '0;
    end
    else
    begin
      dw_q <= dw_d;
      st_q <= st_d;
      rec_q <= rec_d;
      retry_q <= retry_d;
      nak_q <= nak_d;
      token_q <= token_d;
      acc_q <= acc_d;
      cause_q <= cause_d;
      next_cause_q <= next_cause_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      xv_q <= xv_d;
      tok_o_q <= dw_q[1][W1_TOKEN_LSB +: 2];
      func_q <= dw_q[1][W1_FUNC_LSB +: 7];
      ep_q <= {dw_q[1][W1_EP_HIGH_LSB +: 3], dw_q[0][W0_EP_LOW]};
      split_q <= dw_q[1][W1_SPLIT];
      bulk_q <= dw_q[1][W1_TYPE_LSB +: 2] == TYPE_BULK;
      mult_q <= dw_q[0][W0_MULT_LSB +: 2];
      pay_q <= dw_q[2][W2_PAYLOAD_LSB +: 16];
      cpu_q <= (CPU_ADDR_W'(dw_q[2][W2_PAYLOAD_LSB +: 16]) << PAYLOAD_SHIFT) + PAYLOAD_BASE;
    end
  end

  assign PRDATA_O = prdata_q;
  assign PREADY_O = pready_q;
  assign PSLVERR_O = pslverr_q;
  assign XFER_VALID_O = xv_q;
  assign TOKEN_O = tok_o_q;
  assign FUNC_ADDR_O = func_q;
  assign ENDPOINT_O = ep_q;
  assign SPLIT_O = split_q;
  assign BULK_O = bulk_q;
  assign MULT_O = mult_q;
  assign PAYLOAD_START_O = pay_q;
  assign PAYLOAD_CPU_ADDR_O = cpu_q;
endmodule : hsad_async_desc

// ---- hsad_pkg.sv ----
package hsad_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int BYTES_W = 15;
  localparam int FIFO_W = 17;
  localparam int FIFO_DEPTH = 16;
  localparam int CPU_ADDR_W = 20;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] OFS_WORD0 = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_WORD1 = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_WORD2 = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_WORD3 = 12'h00C;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h010;
  localparam logic [DATA_W-1:0] WORD_RESET = 32'h0000_0000;

  // Word 0 fields
  localparam int W0_VALID = 0;
  localparam int W0_TOTAL_LSB = 3;
  localparam int W0_MULT_LSB = 29;
  localparam int W0_EP_LOW = 31;
  // Word 1 fields
  localparam int W1_EP_HIGH_LSB = 0;
  localparam int W1_FUNC_LSB = 3;
  localparam int W1_TOKEN_LSB = 10;
  localparam int W1_TYPE_LSB = 12;
  localparam int W1_SPLIT = 14;
  // Word 2 fields
  localparam int W2_PAYLOAD_LSB = 8;
  localparam int W2_RELOAD_LSB = 25;
  // Word 3 fields
  localparam int W3_BYTES_LSB = 0;
  localparam int W3_NAK_LSB = 19;
  localparam int W3_RETRY_LSB = 23;

  localparam logic [1:0] TOKEN_OUT = 2'h0;
  localparam logic [1:0] TOKEN_IN = 2'h1;
  localparam logic [1:0] TOKEN_SETUP = 2'h2;
  localparam logic [1:0] TOKEN_PING = 2'h3;
  localparam logic [1:0] TYPE_CONTROL = 2'h0;
  localparam logic [1:0] TYPE_BULK = 2'h2;
  localparam logic [1:0] MULT_UNDEF = 2'h0;
  localparam logic [1:0] MULT_ONE = 2'h1;

  localparam logic [1:0] RES_ACK = 2'h0;
  localparam logic [1:0] RES_NAK = 2'h1;
  localparam logic [1:0] RES_ERR = 2'h2;

  localparam logic [1:0] CAUSE_NONE = 2'h0;
  localparam logic [1:0] CAUSE_DONE = 2'h1;
  localparam logic [1:0] CAUSE_NAK = 2'h2;
  localparam logic [1:0] CAUSE_ERR = 2'h3;

  localparam logic [CPU_ADDR_W-1:0] PAYLOAD_BASE = 20'h00400;
  localparam int PAYLOAD_SHIFT = 3;

  typedef enum logic [1:0] {ST_IDLE, ST_EVAL, ST_WB, ST_RETIRE} hsad_state_t;

endpackage : hsad_pkg
